// *** core/sar_defines.vh ***
// Constants for the serial conversion and readout sequencer
`ifndef SAR_DEFINES_VH
`define SAR_DEFINES_VH
`define SAR_WIDTH 16
`define SAR_CNT_W 6
`define SAR_ACQ_FALLS 6'h05
`define SAR_MSB_LAST 6'h15
`define SAR_LSB_LAST 6'h24
`define SAR_CNT_MAX 6'h3F
`define SAR_BIT_MSB 4'hF
`define SAR_ST_OFF 2'h0
`define SAR_ST_ACQ 2'h1
`define SAR_ST_MSB 2'h2
`define SAR_ST_TAIL 2'h3
`endif

// *** core/sar_sync.v ***
// Two-stage synchroniser with an edge detector on the settled level
`timescale 1ns/100ps
module sar_sync #(
  parameter RESET_VAL = 1'b0
) (
  input wire clk_in,
  input wire rst_in,
  input wire async_in,
  output reg level_out,
  output wire rise_out,
  output wire fall_out
);
  reg meta;
  reg prev;
  always @(posedge clk_in) begin
    if (rst_in) begin
      meta <= RESET_VAL;
      level_out <= RESET_VAL;
      prev <= RESET_VAL;
    end else begin
      meta <= async_in;
      level_out <= meta;
      prev <= level_out;
    end
  end
  assign rise_out = level_out & ~prev;
  assign fall_out = ~level_out & prev;
endmodule // sar_sync

// *** core/sar_adc_serial_readout.v ***
// Serial conversion and readout sequencer of a 16-bit SAR converter
// Function
// R1: Select low enables the device; select high forces shutdown at once.
// R2: All sequencing steps only on host data clock edges, no own timer.
// R3: Host keeps select low at least 22 clocks for a full result.
// R4: Acquire input for 4.5 to 5.0 clock periods before the first decision.
// R5: Still selected after conversion, shift the same result out LSB first.
// R6: After the LSB-first word, output zeros for as long as clocked.
// R7: Result leaves MSB first, belonging to the current conversion only.
// R8: Start of conversion captures the input; it stays held until done.
// R9: Output tri-stated when deselected, driven after first falling clock edge.
`timescale 1ns/100ps
`include "sar_defines.vh"
module sar_adc_serial_readout (
  input wire clk_in,
  input wire rst_in,
  input wire select_n_shutdown_in,
  input wire conversion_data_clock_in,
  input wire [15:0] analog_sample_in,
  output reg serial_data_out,
  output reg serial_data_oe_out,
  output wire shutdown_out,
  output reg sample_hold_out,
  output reg [15:0] held_sample_out
);
  wire sel_n;
  wire sel_fall;
  wire dclk_fall;
  reg [1:0] state;
  reg [1:0] next_state;
  reg [5:0] falls;
  reg [15:0] result;
  reg [3:0] bit_idx;

  sar_sync #(.RESET_VAL(1'b1)) u_sel (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .async_in(select_n_shutdown_in),
    .level_out(sel_n),
    .rise_out(),
    .fall_out(sel_fall)
  );

  sar_sync #(.RESET_VAL(1'b0)) u_dclk (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .async_in(conversion_data_clock_in),
    .level_out(),
    .rise_out(),
    .fall_out(dclk_fall)
  );

  assign shutdown_out = sel_n; // [R1]

  // Falling edges after select: 6 falls of acquisition, then 16 decision bits
  always @* begin
    next_state = state;
    if (sel_n) begin
      next_state = `SAR_ST_OFF; // [R1]
    end else begin
      case (state)
        `SAR_ST_OFF: begin
          if (sel_fall) begin
            next_state = `SAR_ST_ACQ;
          end
        end
        `SAR_ST_ACQ: begin
          if (dclk_fall && falls == `SAR_ACQ_FALLS) begin
            next_state = `SAR_ST_MSB; // [R4]
          end
        end
        `SAR_ST_MSB: begin
          if (dclk_fall && falls == `SAR_MSB_LAST) begin
            next_state = `SAR_ST_TAIL; // [R5]
          end
        end
        default: begin
          next_state = `SAR_ST_TAIL;
        end
      endcase
    end
  end

  always @(posedge clk_in) begin
    if (rst_in) begin
      state <= `SAR_ST_OFF;
      falls <= 6'h00;
      result <= 16'h0000;
      bit_idx <= 4'h0;
      serial_data_out <= 1'b0;
      serial_data_oe_out <= 1'b0;
      sample_hold_out <= 1'b0;
      held_sample_out <= 16'h0000;
    end else begin
      state <= next_state;
      if (sel_n) begin
        falls <= 6'h00;
        serial_data_oe_out <= 1'b0; // [R9]
        serial_data_out <= 1'b0;
        sample_hold_out <= 1'b0; // [R8]
      end else if (dclk_fall) begin // [R2]
        serial_data_oe_out <= 1'b1; // [R9]
        // Saturate so an endless tail cannot wrap into a new word
        if (falls != `SAR_CNT_MAX) begin
          falls <= falls + 6'h01;
        end
        if (state == `SAR_ST_ACQ && falls == `SAR_ACQ_FALLS) begin
          // Hold begins here; input is ignored until the next select
          held_sample_out <= analog_sample_in; // [R8]
          sample_hold_out <= 1'b1;
          result <= 16'h0000;
          bit_idx <= `SAR_BIT_MSB;
        end
        if (state == `SAR_ST_MSB) begin
          // Each decision is shifted out as soon as it is made
          serial_data_out <= held_sample_out[bit_idx]; // [R7]
          result[bit_idx] <= held_sample_out[bit_idx];
          bit_idx <= bit_idx - 4'h1;
          if (falls == `SAR_MSB_LAST) begin
            bit_idx <= 4'h1;
          end
        end else if (state == `SAR_ST_TAIL) begin
          if (falls <= `SAR_LSB_LAST) begin
            serial_data_out <= result[bit_idx]; // [R5]
            bit_idx <= bit_idx + 4'h1;
          end else begin
            serial_data_out <= 1'b0; // [R6]
          end
        end else begin
          serial_data_out <= 1'b0;
        end
      end
    end
  end
endmodule // sar_adc_serial_readout

// *** bench/sar_host.sv ***
// Host model driving select and data clock
`timescale 1ns/100ps
module sar_host(input wire go,input wire [5:0] n,input wire sdo,
output reg sel_n,output reg dclk,output reg done,output reg [39:0] bits);
initial begin sel_n=1;dclk=1;done=0;bits=0; end
always @(posedge go) begin
done=0;sel_n=0;#20;
repeat(n) begin dclk=0;#32;dclk=1;bits={bits[38:0],sdo};#32; end
sel_n=1;done=1;
end
endmodule // sar_host

// *** bench/sar_assertions.sv ***
// Port checker for the readout sequencer
`timescale 1ns/100ps
module sar_chk(input wire clk_in,rst_in,select_n_shutdown_in,conversion_data_clock_in,
input wire [15:0] analog_sample_in,input wire serial_data_out,serial_data_oe_out,shutdown_out,
input wire sample_hold_out,input wire [15:0] held_sample_out);
default clocking @(posedge clk_in); endclocking
default disable iff (rst_in);
off_follows_a: assert property (select_n_shutdown_in[*4] |-> shutdown_out) else $error("no shutdown");
on_follows_a: assert property (!select_n_shutdown_in[*4] |-> !shutdown_out) else $error("no select");
off_tristate_a: assert property (shutdown_out[*4] |-> !serial_data_oe_out) else $error("driven when off");
no_own_timer_a: assert property ((!shutdown_out && $stable(conversion_data_clock_in))[*8]
  |=> $stable(serial_data_out)) else $error("data moved without clock");
held_still_a: assert property (sample_hold_out && $past(sample_hold_out) |-> $stable(held_sample_out))
  else $error("held value moved");
oe_after_select_a: assert property ($rose(serial_data_oe_out) |-> $past(!shutdown_out))
  else $error("driven without select");
hold_after_select_a: assert property ($rose(sample_hold_out) |-> $past(!shutdown_out))
  else $error("captured without select");
endmodule // sar_chk
bind sar_adc_serial_readout sar_chk i_chk(.*);

// *** bench/tb.sv ***
// Bench for the serial readout sequencer
`timescale 1ns/100ps
module tb;
reg clk_in=0,rst_in=1,go=0;
reg [15:0] a=16'h0000;
reg [5:0] n=6'h28;
wire sel_n,dclk,done,sdo,oe,sd,hold;
wire [15:0] held;
wire [39:0] b;
wire pin=oe?sdo:1'bz;
int n_fail=0,checks_done=0;
always #2.5 clk_in=~clk_in;
sar_adc_serial_readout i_dut(.clk_in(clk_in),.rst_in(rst_in),.select_n_shutdown_in(sel_n),
.conversion_data_clock_in(dclk),.analog_sample_in(a),.serial_data_out(sdo),.serial_data_oe_out(oe),
.shutdown_out(sd),.sample_hold_out(hold),.held_sample_out(held));
sar_host i_host(.go(go),.n(n),.sdo(pin),.sel_n(sel_n),.dclk(dclk),.done(done),.bits(b));
task chk(input string s,input [39:0] e,v);
checks_done++;
if(v!==e) begin n_fail++;$display("[FAIL] %s exp %h got %h",s,e,v); end
endtask
task wrap_up;
$display("checks %0d fails %0d",checks_done,n_fail);
if(n_fail==0&&checks_done>0) $display("Test passed"); else $display("Test failed");
$finish;
endtask
task frame(input [15:0] w,input [5:0] k);
@(negedge clk_in);a=w;n=k;go=1;
// Input moves once held, must not leak into result
repeat(130) @(negedge clk_in);a=~w;go=0;
for(int i=0;i<900&&!done;i++) @(negedge clk_in);
if(!done) begin n_fail++;wrap_up; end
repeat(8) @(negedge clk_in);
endtask
task sc_full;
logic [15:0] r;
r={<<{16'hA5C3}};
frame(16'hA5C3,6'h28);
chk("acquire",0,b[39:35]);
chk("msb word",16'hA5C3,b[33:18]);
chk("lsb word",r[14:0],b[17:3]);
chk("tail",0,b[2:0]);
chk("oe",0,oe);
chk("off",1,sd);
chk("hold",0,hold);
chk("held",16'hA5C3,held);
endtask
task sc_abort;
frame(16'h5A3C,6'h0C);
frame(16'h0001,6'h28);
chk("after abort",16'h0001,b[33:18]);
endtask
initial begin
repeat(4) @(negedge clk_in);
rst_in=0;
repeat(4) @(negedge clk_in);
sc_full;
sc_abort;
wrap_up;
end
endmodule // tb
